//--- core/swp_top.sv
// write enable latch, status register and write protection of an spi
// nonvolatile memory; array datapath lies outside and takes arr_wr_out.
// assumes spi pins asynchronous to ref_clk_in, sck well below clk/4.
//
// Operation
// - latch comes up cleared after power-up, so writes are disabled
// - set-latch opcode sets the latch; status bit 1 then reads one
// - master sets latch first; device never writes while latch is clear
// - chip select rise after any write-type command clears the latch
// - status write data leaves latch bit unchanged; select rise still clears it
// - clear-latch opcode clears latch, disabling later write commands
// - status layout: pin enable 7, protect hi 3, protect lo 2, latch 1
// - bits 4, 5 read zero, bit 6 reads one, writes leave them
// - bit 0 reads zero except while waking from a low-power mode
// - block protect bits kept nonvolatile across power cycles
// - protect decode none, upper quarter, upper half, all; blocks writes
// - pin enable zero: write-protect pin level is ignored
// - pin enable one with pin low rejects status writes
// - protect pin gates only status writes, never array writes
// - status read opcode shifts out current status byte
// - array writes run at bus speed with no busy time, unbounded bursts
// - command starts at chip select fall; first byte is the only opcode
// - unknown opcode: ignore input until next select, output stays off
// - sample input on sck rise msb first, drive output on sck fall
// - burst reaching protected address stops increment, drops later data
`timescale 1ns/10ps
`include "swp_cfg.svh"

module swp_top #(
  parameter int          ADDR_W    = `SWP_ADDR_W,
  // opcode of the serial number write; set to the part's real value
  parameter logic [7:0]  SN_WR_OP  = 8'h00
) (
  // clock and reset
  input  wire logic                   ref_clk_in,
  input  wire logic                   rst_in,
  // spi pins
  input  wire logic                   cs_n_in,
  input  wire logic                   sck_in,
  input  wire logic                   si_in,
  input  wire logic                   wp_n_in,
  output logic                        so_out,
  output logic                        so_oe_out,
  // low-power wake status from the power controller
  input  wire logic                   wake_busy_in,
  // nonvolatile store of protect bits
  input  wire swp_pkg::swp_nv_type    nv_status_in,
  output swp_pkg::swp_nv_type         nv_status_out,
  // array write port and state
  output swp_pkg::swp_arr_wr_type     arr_wr_out,
  output logic                        latch_flag_out
);

  // elaboration check: decode is built for a 19-bit array
  if (ADDR_W != `SWP_ADDR_W) begin : g_bad_width
    $error("swp_top: ADDR_W must equal the array address width");
  end

  // pin synchronisers, one per pin
  localparam int NP = `SWP_PIN_COUNT;
  logic [NP-1:0] pins_w;
  logic [NP-1:0] sync1_r;
  logic [NP-1:0] sync2_r;

  assign pins_w = {wake_busy_in, wp_n_in, si_in, sck_in, cs_n_in};

  for (genvar gi = 0; gi < NP; gi++) begin : g_sync
    always_ff @(posedge ref_clk_in) begin
      sync1_r[gi] <= pins_w[gi];
      sync2_r[gi] <= sync1_r[gi];
    end
  end

  logic cs_n_s, sck_s, si_s, wp_n_s, busy_s;

  assign cs_n_s = sync2_r[0];
  assign sck_s  = sync2_r[1];
  assign si_s   = sync2_r[2];
  assign wp_n_s = sync2_r[3];
  assign busy_s = sync2_r[4];

  // edge history of the synchronised pins
  logic cs_prev_r;
  logic sck_prev_r;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      cs_prev_r  <= 1'b1;
      sck_prev_r <= 1'b0;
    end else begin
      cs_prev_r  <= cs_n_s;
      sck_prev_r <= sck_s;
    end
  end

  logic cs_fall_w, cs_rise_w, sck_rise_w, sck_fall_w;

  assign cs_fall_w  = cs_prev_r & ~cs_n_s;
  assign cs_rise_w  = ~cs_prev_r & cs_n_s;
  // mode 0 and 3 both work: only edges while selected count
  assign sck_rise_w = ~cs_n_s & ~cs_prev_r & sck_s & ~sck_prev_r;
  assign sck_fall_w = ~cs_n_s & ~cs_prev_r & ~sck_s & sck_prev_r;

  // control state
  swp_pkg::swp_state_type   state_r,   state_nxt;
  logic [2:0]               bit_r,     bit_nxt;
  logic [7:0]               shift_r,   shift_nxt;
  logic [7:0]               out_r,     out_nxt;
  logic [1:0]               abyte_r,   abyte_nxt;
  logic [`SWP_ADDR_W-1:0]   addr_r,    addr_nxt;
  logic                     wr_cmd_r,  wr_cmd_nxt;
  logic                     discard_r, discard_nxt;
  logic                     latch_r,   latch_nxt;
  logic                     pin_en_r,  pin_en_nxt;
  logic [1:0]               bp_r,      bp_nxt;
  logic                     so_r,      so_nxt;
  logic                     so_oe_r,   so_oe_nxt;
  swp_pkg::swp_arr_wr_type  arr_r,     arr_nxt;

  logic [7:0] byte_w;
  logic       byte_done_w;
  logic       prot_w;
  logic       sr_locked_w;
  logic [7:0] status_w;

  assign byte_w      = {shift_r[6:0], si_s};
  assign byte_done_w = sck_rise_w && (bit_r == `SWP_BIT_LAST);
  // pin matters only with pin enable set, and only for status writes
  assign sr_locked_w = pin_en_r & ~wp_n_s;

  // status image
  always_comb begin
    status_w                      = 8'h00;
    status_w[`SWP_ST_PIN_EN]      = pin_en_r;
    status_w[`SWP_ST_FIXED_ONE]   = 1'b1;
    status_w[`SWP_ST_BP_HI]       = bp_r[1];
    status_w[`SWP_ST_BP_LO]       = bp_r[0];
    status_w[`SWP_ST_LATCH]       = latch_r;
    status_w[`SWP_ST_BUSY]        = busy_s;
  end

  swp_protect_decode u_decode (
    .bp_in         (bp_r),
    .addr_in       (addr_r),
    .protected_out (prot_w)
  );

  always_comb begin
    state_nxt   = state_r;
    bit_nxt     = bit_r;
    shift_nxt   = shift_r;
    out_nxt     = out_r;
    abyte_nxt   = abyte_r;
    addr_nxt    = addr_r;
    wr_cmd_nxt  = wr_cmd_r;
    discard_nxt = discard_r;
    latch_nxt   = latch_r;
    pin_en_nxt  = pin_en_r;
    bp_nxt      = bp_r;
    so_nxt      = so_r;
    so_oe_nxt   = so_oe_r;
    arr_nxt     = arr_r;
    arr_nxt.en  = 1'b0;
    if (cs_fall_w) begin
      state_nxt   = swp_pkg::ST_OP;
      bit_nxt     = `SWP_BIT_ZERO;
      wr_cmd_nxt  = 1'b0;
      discard_nxt = 1'b0;
      so_oe_nxt   = 1'b0;
    end else if (cs_rise_w) begin
      // blocked writes still consume the latch
      if (wr_cmd_r) begin
        latch_nxt = 1'b0;
      end
      wr_cmd_nxt = 1'b0;
      state_nxt  = swp_pkg::ST_IGNORE;
      so_oe_nxt  = 1'b0;
    end else if (sck_rise_w) begin
      shift_nxt = byte_w;
      bit_nxt   = bit_r + `SWP_BIT_ONE;
      if (byte_done_w) begin
        unique case (state_r)
          swp_pkg::ST_OP: begin
            state_nxt = swp_pkg::ST_IGNORE;
            if (byte_w == `SWP_OP_SET_LATCH) begin
              latch_nxt = 1'b1;
            end else if (byte_w == `SWP_OP_CLR_LATCH) begin
              wr_cmd_nxt = 1'b1;
            end else if (byte_w == `SWP_OP_STAT_RD) begin
              state_nxt = swp_pkg::ST_STAT_RD;
              out_nxt   = status_w;
            end else if (byte_w == `SWP_OP_STAT_WR) begin
              state_nxt  = swp_pkg::ST_STAT_WR;
              wr_cmd_nxt = 1'b1;
            end else if (byte_w == `SWP_OP_ARR_WR) begin
              state_nxt  = swp_pkg::ST_ADDR;
              abyte_nxt  = `SWP_ADDR_BYTE_ZERO;
              wr_cmd_nxt = 1'b1;
            end else if (byte_w == `SWP_OP_SPEC_WR ||
                         byte_w == SN_WR_OP) begin
              // datapath for these lives elsewhere; only the latch here
              wr_cmd_nxt = 1'b1;
            end
          end
          swp_pkg::ST_STAT_WR: begin
            // commit only on the full byte; latch bit is never written
            if (latch_r && !sr_locked_w) begin
              pin_en_nxt = byte_w[`SWP_ST_PIN_EN];
              bp_nxt     = {byte_w[`SWP_ST_BP_HI],
                            byte_w[`SWP_ST_BP_LO]};
            end
            state_nxt = swp_pkg::ST_IGNORE;
          end
          swp_pkg::ST_ADDR: begin
            // upper five address bits fall off the top
            addr_nxt = {addr_r[`SWP_ADDR_W-9:0], byte_w};
            if (abyte_r == `SWP_ADDR_BYTE_LAST) begin
              state_nxt = swp_pkg::ST_DATA;
            end
            abyte_nxt = abyte_r + `SWP_ADDR_BYTE_ONE;
          end
          swp_pkg::ST_DATA: begin
            if (!discard_r) begin
              if (prot_w) begin
                discard_nxt = 1'b1;
              end else begin
                // no page buffer: each byte goes out as it completes
                arr_nxt.en   = latch_r;
                arr_nxt.addr = addr_r;
                arr_nxt.data = byte_w;
                addr_nxt     = (addr_r == `SWP_ADDR_LAST) ? `SWP_ADDR_ZERO :
                               addr_r + `SWP_ADDR_ONE;
              end
            end
          end
          swp_pkg::ST_STAT_RD: begin
            out_nxt = status_w;
          end
          swp_pkg::ST_IGNORE: begin
            state_nxt = swp_pkg::ST_IGNORE;
          end
        endcase
      end
    end else if (sck_fall_w && state_r == swp_pkg::ST_STAT_RD) begin
      so_nxt    = out_r[7];
      out_nxt   = {out_r[6:0], out_r[7]};
      so_oe_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_r   <= swp_pkg::ST_IGNORE;
      bit_r     <= `SWP_BIT_ZERO;
      shift_r   <= 8'h00;
      out_r     <= 8'h00;
      abyte_r   <= `SWP_ADDR_BYTE_ZERO;
      addr_r    <= `SWP_ADDR_ZERO;
      wr_cmd_r  <= 1'b0;
      discard_r <= 1'b0;
      latch_r   <= 1'b0;
      // protect bits are restored from the nonvolatile store
      pin_en_r  <= nv_status_in.pin_en;
      bp_r      <= nv_status_in.bp;
      so_r      <= 1'b0;
      so_oe_r   <= 1'b0;
      arr_r     <= '0;
    end else begin
      state_r   <= state_nxt;
      bit_r     <= bit_nxt;
      shift_r   <= shift_nxt;
      out_r     <= out_nxt;
      abyte_r   <= abyte_nxt;
      addr_r    <= addr_nxt;
      wr_cmd_r  <= wr_cmd_nxt;
      discard_r <= discard_nxt;
      latch_r   <= latch_nxt;
      pin_en_r  <= pin_en_nxt;
      bp_r      <= bp_nxt;
      so_r      <= so_nxt;
      so_oe_r   <= so_oe_nxt;
      arr_r     <= arr_nxt;
    end
  end

  assign so_out         = so_r;
  assign so_oe_out      = so_oe_r;
  assign arr_wr_out     = arr_r;
  assign latch_flag_out = latch_r;
  assign nv_status_out  = {pin_en_r, bp_r};

  // checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  AST_LATCH_AFTER_RESET: assert property (
    @(posedge ref_clk_in) disable iff (1'b0)
    rst_in |=> !latch_r)
    else $error("latch not clear after reset");
  AST_SET_LATCH: assert property (
    byte_done_w && state_r == swp_pkg::ST_OP &&
    byte_w == `SWP_OP_SET_LATCH |=> latch_r && status_w[`SWP_ST_LATCH])
    else $error("set latch opcode did not set the latch");
  AST_NO_WRITE_UNLATCHED: assert property (
    arr_r.en |-> $past(latch_r))
    else $error("array write without latch");
  AST_CLEAR_ON_RISE: assert property (
    cs_rise_w && wr_cmd_r |=> !latch_r)
    else $error("latch survived end of write command");
  AST_STATUS_WR_KEEPS_LATCH: assert property (
    byte_done_w && state_r == swp_pkg::ST_STAT_WR |=> $stable(latch_r))
    else $error("status write changed the latch");
  // arming is enough: the select rise check above finishes the clear
  AST_CLEAR_CMD_ARMS: assert property (
    byte_done_w && state_r == swp_pkg::ST_OP &&
    byte_w == `SWP_OP_CLR_LATCH |=> wr_cmd_r)
    else $error("clear latch opcode did not arm the clear");
  AST_FIXED_BITS: assert property (
    status_w[`SWP_ST_FIXED_ONE] &&
    !status_w[`SWP_ST_ZERO_HI] && !status_w[`SWP_ST_ZERO_LO])
    else $error("fixed status bits wrong");
  AST_PIN_LOCK: assert property (
    byte_done_w && state_r == swp_pkg::ST_STAT_WR && sr_locked_w
    |=> $stable(bp_r) && $stable(pin_en_r))
    else $error("status written while protect pin locked");
  AST_PROTECTED_NO_WRITE: assert property (
    byte_done_w && state_r == swp_pkg::ST_DATA && prot_w |=> !arr_r.en)
    else $error("write into protected block");
  AST_DISCARD_HOLDS_ADDR: assert property (
    discard_r && !cs_fall_w |=> $stable(addr_r) && !arr_r.en)
    else $error("address moved after protected hit");
  AST_IGNORE_TRISTATE: assert property (
    state_r == swp_pkg::ST_IGNORE |-> !so_oe_r)
    else $error("serial output driven while ignoring");

endmodule : swp_top

//--- core/swp_cfg.svh
// constants for the write protect and status block of the serial memory
// assumes inclusion by bare name from every core file that needs them
`ifndef SWP_CFG_SVH
`define SWP_CFG_SVH

// opcodes
`define SWP_OP_SET_LATCH   8'h06
`define SWP_OP_CLR_LATCH   8'h04
`define SWP_OP_STAT_RD     8'h05
`define SWP_OP_STAT_WR     8'h01
`define SWP_OP_ARR_WR      8'h02
`define SWP_OP_SPEC_WR     8'h42

// status bit positions
`define SWP_ST_PIN_EN      7
`define SWP_ST_FIXED_ONE   6
`define SWP_ST_ZERO_HI     5
`define SWP_ST_ZERO_LO     4
`define SWP_ST_BP_HI       3
`define SWP_ST_BP_LO       2
`define SWP_ST_LATCH       1
`define SWP_ST_BUSY        0

// block protect codes and bounds
`define SWP_BP_NONE        2'h0
`define SWP_BP_QUARTER     2'h1
`define SWP_BP_HALF        2'h2
`define SWP_BP_ALL         2'h3
`define SWP_QTR_BASE       19'h6_0000
`define SWP_HALF_BASE      19'h4_0000
`define SWP_ADDR_LAST      19'h7_FFFF
`define SWP_ADDR_ONE       19'h0_0001
`define SWP_ADDR_ZERO      19'h0_0000

// widths and counts
`define SWP_ADDR_W         19
`define SWP_BIT_LAST       3'h7
`define SWP_BIT_ONE        3'h1
`define SWP_BIT_ZERO       3'h0
`define SWP_ADDR_BYTE_LAST 2'h2
`define SWP_ADDR_BYTE_ONE  2'h1
`define SWP_ADDR_BYTE_ZERO 2'h0
`define SWP_PIN_COUNT      5
`define SWP_NV_RESET       3'h0

`endif

//--- core/swp_pkg.sv
// types shared by the write protect and status block
// assumes swp_cfg.svh is on the include path
`include "swp_cfg.svh"

package swp_pkg;

  typedef enum logic [2:0] {
    ST_OP,
    ST_STAT_WR,
    ST_STAT_RD,
    ST_ADDR,
    ST_DATA,
    ST_IGNORE
  } swp_state_type;

  // one array byte write toward the memory core
  typedef struct packed {
    logic                     en;
    logic [`SWP_ADDR_W-1:0]   addr;
    logic [7:0]               data;
  } swp_arr_wr_type;

  // nonvolatile part of the status register
  typedef struct packed {
    logic       pin_en;
    logic [1:0] bp;
  } swp_nv_type;

endpackage : swp_pkg

//--- core/swp_protect_decode.sv
// block protect decode: is an array address inside the protected range
// assumes a full 19-bit array address and two block protect bits
`timescale 1ns/10ps
`include "swp_cfg.svh"

module swp_protect_decode (
  // protect setting
  input  wire logic [1:0]             bp_in,
  // address under test
  input  wire logic [`SWP_ADDR_W-1:0] addr_in,
  // decision
  output logic                        protected_out
);

  always_comb begin
    unique case (bp_in)
      `SWP_BP_NONE:    protected_out = 1'b0;
      `SWP_BP_QUARTER: protected_out = (addr_in >= `SWP_QTR_BASE) &&
                                       (addr_in <= `SWP_ADDR_LAST);
      `SWP_BP_HALF:    protected_out = (addr_in >= `SWP_HALF_BASE) &&
                                       (addr_in <= `SWP_ADDR_LAST);
      `SWP_BP_ALL:     protected_out = 1'b1;
    endcase
  end

endmodule : swp_protect_decode

//--- bench/swp_spi_master.sv
// behavioural spi bus master driving the write protect block in mode 0
// assumes the caller sequences frames; sck stands low outside frames
`timescale 1ns/10ps

module swp_spi_master (
  // spi pins toward the device
  output logic      cs_n_out,
  output logic      sck_out,
  output logic      si_out,
  input  wire logic so_in,
  input  wire logic so_oe_in
);
  localparam time HALF = 80ns;

  initial begin
    cs_n_out = 1'b1;
    sck_out  = 1'b0;
    si_out   = 1'b0;
  end

  // nbits from the top of d; rd keeps the last eight so samples
  task automatic frame(input logic [63:0] d, input int nbits,
                       output logic [7:0] rd, output logic [7:0] oe_cnt);
    rd = 8'h00;
    oe_cnt = 8'h00;
    cs_n_out <= 1'b0; // every command opens with a select fall
    for (int i = 0; i < nbits; i++) begin
      si_out <= d[63-i]; // msb first, changed after the fall
      #HALF;
      sck_out <= 1'b1;
      rd = {rd[6:0], so_in}; // sampled at the rise
      oe_cnt = oe_cnt + {7'h00, so_oe_in};
      #HALF;
      sck_out <= 1'b0;
    end
    #HALF;
    cs_n_out <= 1'b1;
    // released line must not keep showing the last bit
    si_out <= ~si_out;
    #(2*HALF);
  endtask : frame
endmodule : swp_spi_master

//--- bench/swp_top_test.sv
// self-checking bench for the write protect and status block
// assumes swp_pkg compiled first and the spi master model beside it
`timescale 1ns/10ps

module swp_top_test;
  localparam logic [7:0] SN_OP = 8'h3C; // arbitrary opcode value
  localparam int         LIMIT = 60000;

  typedef struct packed {
    logic       wp_n;
    logic       set_latch_cmd;
    logic [7:0] val;
    logic [7:0] exp;
  } swp_row_type;

  logic                    ref_clk_in;
  logic                    rst_in;
  logic                    cs_n;
  logic                    sck;
  logic                    si;
  logic                    wp_n_in;
  logic                    wake_busy_in;
  logic                    so;
  logic                    so_oe;
  logic                    latch;
  swp_pkg::swp_nv_type     nv_in;
  swp_pkg::swp_nv_type     nv_out;
  swp_pkg::swp_arr_wr_type arr_wr;
  int                      mismatches;
  int                      comparisons;
  int                      cycles;
  int                      wr_count;
  int                      n0;
  logic [18:0]             last_addr;
  logic [7:0]              last_data;
  logic [7:0]              rd;
  logic [7:0]              oe_cnt;

  // status write cases: pin, latch first, value, expected readback
  swp_row_type rows [6] = '{
    '{1'b1, 1'b1, 8'hFF, 8'hCC},
    '{1'b0, 1'b1, 8'h00, 8'hCC},
    '{1'b1, 1'b0, 8'h00, 8'hCC},
    '{1'b1, 1'b1, 8'h04, 8'h44},
    '{1'b0, 1'b1, 8'h08, 8'h48},
    '{1'b0, 1'b1, 8'h00, 8'h40}};
  logic [7:0]  ops [5]   = '{8'h04, 8'h01, 8'h02, 8'h42, SN_OP};
  logic [18:0] start [4] = '{19'h7_FFFF, 19'h5_FFFF, 19'h5_FFFF,
                             19'h5_FFFF};
  int          wr_exp [4] = '{2, 1, 0, 0};

  swp_top #(
    .ADDR_W   (19),
    .SN_WR_OP (SN_OP)
  ) u_dut (
    .ref_clk_in     (ref_clk_in),
    .rst_in         (rst_in),
    .cs_n_in        (cs_n),
    .sck_in         (sck),
    .si_in          (si),
    .wp_n_in        (wp_n_in),
    .so_out         (so),
    .so_oe_out      (so_oe),
    .wake_busy_in   (wake_busy_in),
    .nv_status_in   (nv_in),
    .nv_status_out  (nv_out),
    .arr_wr_out     (arr_wr),
    .latch_flag_out (latch)
  );

  swp_spi_master u_master (
    .cs_n_out (cs_n),
    .sck_out  (sck),
    .si_out   (si),
    .so_in    (so),
    .so_oe_in (so_oe)
  );

  initial ref_clk_in = 1'b0;
  always #2.5 ref_clk_in = ~ref_clk_in;

  // array write monitor and hang guard
  always @(posedge ref_clk_in) begin
    cycles++;
    if (arr_wr.en === 1'b1) begin
      wr_count++;
      last_addr = arr_wr.addr;
      last_data = arr_wr.data;
    end
    if (cycles == LIMIT) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic check(input logic [18:0] seen, input logic [18:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    if (mismatches == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  task automatic send(input logic [63:0] d, input int n);
    u_master.frame(d, n, rd, oe_cnt);
  endtask : send

  // latch set in its own frame, the opcode byte alone
  task automatic set_latch_cmd;
    send({8'h06, 56'h0}, 8);
  endtask : set_latch_cmd

  task automatic rd_status;
    send({8'h05, 56'h0}, 16);
  endtask : rd_status

  task automatic set_wp(input logic v);
    @(posedge ref_clk_in);
    wp_n_in <= v;
  endtask : set_wp

  initial begin
    rst_in = 1'b1;
    wp_n_in = 1'b1;
    wake_busy_in = 1'b0;
    nv_in = 3'h1;
    mismatches = 0;
    comparisons = 0;
    cycles = 0;
    wr_count = 0;
    repeat (16) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    check(latch, 1'b0);
    check(nv_out, 3'h1);
    rd_status();
    check(rd, 8'h44);
    check(oe_cnt, 8'h08);
    foreach (rows[i]) begin
      set_wp(rows[i].wp_n);
      if (rows[i].set_latch_cmd) begin
        set_latch_cmd();
        check(latch, 1'b1);
      end
      send({8'h01, rows[i].val, 48'h0}, 16);
      check(latch, 1'b0);
      rd_status();
      check(rd, rows[i].exp);
    end
    set_wp(1'b1);
    set_latch_cmd();
    rd_status();
    check(rd, 8'h42);
    send({8'h04, 56'h0}, 8);
    rd_status();
    check(rd, 8'h40);
    // each write-type opcode alone still drops the latch
    foreach (ops[i]) begin
      set_latch_cmd();
      send({ops[i], 56'h0}, 8);
      check(latch, 1'b0);
    end
    // status data cut short by select rise
    set_latch_cmd();
    send({8'h01, 8'h8C, 48'h0}, 12);
    rd_status();
    check(rd, 8'h40);
    set_wp(1'b1);
    wake_busy_in <= 1'b1;
    rd_status();
    check(rd, 8'h41);
    @(posedge ref_clk_in);
    wake_busy_in <= 1'b0;
    send({8'hFF, 8'h06, 48'h0}, 16);
    check(latch, 1'b0);
    check(oe_cnt, 8'h00);
    send({8'h06, 8'h05, 48'h0}, 16);
    check(latch, 1'b1);
    check(oe_cnt, 8'h00);
    send({8'h04, 56'h0}, 8);
    n0 = wr_count;
    send({8'h02, 24'h05_FFFF, 8'hA5, 8'h5A, 16'h0000}, 48);
    check(19'(wr_count - n0), 19'h0);
    // one burst per protect code, protect pin low and enabled
    for (int b = 0; b < 4; b++) begin
      set_wp(1'b1);
      set_latch_cmd();
      send({8'h01, 1'b1, 3'h0, 2'(b), 2'h0, 48'h0}, 16);
      set_wp(1'b0);
      set_latch_cmd();
      n0 = wr_count;
      send({8'h02, 5'h00, start[b], 8'hA5, 8'h5A, 16'h0000}, 48);
      check(19'(wr_count - n0), 19'(wr_exp[b]));
      check(latch, 1'b0);
      if (b == 0) begin
        check(last_addr, 19'h0_0000);
        check(last_data, 8'h5A);
      end
      if (b == 1)
        check(last_addr, 19'h5_FFFF);
    end
    // reset in mid-run drops the latch and reloads the stored bits
    set_latch_cmd();
    check(latch, 1'b1);
    rst_in <= 1'b1;
    nv_in  <= 3'h6;
    repeat (3) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    check(latch, 1'b0);
    check(nv_out, 3'h6);
    rd_status();
    check(rd, 8'hC8);
    complete_run();
  end
endmodule : swp_top_test
